// *** eeprom_host.sv ***
// Functional notes
// R01: device holds sixteen 16-bit words selected by a serial word address
// R02: three-bit parallel code picks each operation; clock strobes code and shifts bits
// R03: under address-in code, host shifts four address bits, one per clock
// R04: one clock under read code loads addressed word into device data register
// R05: under data-out code device drives pin and shifts sixteen bits out
// R06: under data-in code host shifts sixteen data bits into device register
// R07: one clock strobes word erase; host holds that code at least 100 ms
// R08: one clock strobes write; after at least 10 ms host strobes standby
// R09: device takes a new code after one clock pulse with it present
// R10: either standby code makes device quiescent, pin floats, clock ignored
// R11: device drives the serial pin only while shifting out read data
// R12: deselected device ignores clock and floats pin, keeping its operation
// R13: device voltage control output active only after erase or write code
// R14: whole-array clear erases all; host applies programming voltage itself
// R15: an erased bit reads as logical zero
// R16: host always erases an address before writing it
// R17: host may erase before shifting new data into the register
// R18: host holds all device inputs stable while programming voltage is on; the link clock still falls once after vpp_enable_o rises
// R19: codes: erase 100, write 010, out 110, addr 001, in 101, read 011, standby 111/000
// R20: bits and codes sampled on the rising clock edge
// R21: address and data shift most significant bit first
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_defines.svh"
module eeprom_host #(
	parameter int ERASE_CYC = `ERASE_CYCLES,
	parameter int PROGRAM_CYC = `PROGRAM_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// command stream
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire eeprom_host_pkg::cmd_t cmd_i,
	// read answers and busy flag
	output logic rsp_valid_o,
	output eeprom_host_pkg::rsp_t rsp_o,
	output logic busy_o,
	// device pins
	output logic link_clk_o,
	output logic [2:0] op_code_pins_o,
	output logic select_n_o,
	output logic whole_array_clear_o,
	output logic vpp_enable_o,
	input wire logic prog_voltage_ctl_out_i,
	input wire logic serial_addr_data_io_i,
	output logic serial_addr_data_io_o,
	output logic serial_addr_data_io_oe_o
);
	import eeprom_host_pkg::*;
	typedef enum logic [7:0] {
		ST_IDLE = 8'h01,
		ST_ADDR = 8'h02,
		ST_READ = 8'h04,
		ST_DOUT = 8'h08,
		ST_DIN = 8'h10,
		ST_ERASE = 8'h20,
		ST_PROG = 8'h40,
		ST_STBY = 8'h80
	} state_t;
	localparam logic [7:0] PHASE = 8'(`PHASE_CYCLES);
	////////////////////////////////////////////////////////////////////////////////
	// command queue; back-pressure reaches the source through cmd_ready_o
	logic q_valid;
	logic q_ready;
	cmd_t q_cmd;
	word_fifo #(.WIDTH($bits(cmd_t)), .DEPTH(`FIFO_DEPTH)) u_word_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(cmd_valid_i),
		.in_ready_o(cmd_ready_o),
		.in_data_i(cmd_i),
		.out_valid_o(q_valid),
		.out_ready_i(q_ready),
		.out_data_o(q_cmd)
	);
	////////////////////////////////////////////////////////////////////////////////
	// link clock: phase counter makes one pulse per strobe
	state_t state_reg;
	logic held_reg;
	cmd_t cur_reg;
	logic [7:0] ph_reg;
	logic pulse_on_reg;
	logic [4:0] bits_reg;
	logic [15:0] sh_reg;
	logic [31:0] wait_reg;
	logic erased_reg;
	logic fall;
	logic rise;
	// sample just before the falling edge so read data has settled a whole phase
	assign rise = (ph_reg == PHASE - 8'h01) && !pulse_on_reg;
	assign fall = (ph_reg == PHASE - 8'h01) && pulse_on_reg;
	function automatic logic pulsing(input state_t s);
		pulsing = (s == ST_ADDR) || (s == ST_READ) || (s == ST_DOUT) || (s == ST_DIN) ||
			(s == ST_STBY) ||
			((s == ST_ERASE || s == ST_PROG) && !held_reg && !whole_array_clear_o);
	endfunction
	assign q_ready = (state_reg == ST_IDLE);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ph_reg <= 8'h00;
			pulse_on_reg <= 1'b0;
			link_clk_o <= 1'b0;
		end else if (!pulsing(state_reg) && !pulse_on_reg) begin
			ph_reg <= 8'h00;
		end else if (ph_reg == PHASE - 8'h01) begin
			ph_reg <= 8'h00;
			pulse_on_reg <= !pulse_on_reg;
			link_clk_o <= !pulse_on_reg; // rising edge strobes code and bits [R20]
		end else begin
			ph_reg <= ph_reg + 8'h01;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_IDLE;
			held_reg <= 1'b0;
			cur_reg <= '0;
			bits_reg <= 5'h00;
			sh_reg <= 16'h0000;
			wait_reg <= '0;
			erased_reg <= 1'b0;
			rsp_valid_o <= 1'b0;
			rsp_o <= '0;
			busy_o <= 1'b0;
			op_code_pins_o <= `OPC_STANDBY_LO;
			select_n_o <= 1'b1;
			whole_array_clear_o <= 1'b0;
			vpp_enable_o <= 1'b0;
			serial_addr_data_io_o <= 1'b0;
		end else begin
			rsp_valid_o <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					busy_o <= q_valid;
					if (q_valid) begin
						cur_reg <= q_cmd;
						select_n_o <= 1'b0;
						if (q_cmd.kind == CMD_CLEAR) begin
							// clear gives no voltage control; host powers it for the erase time [R14]
							whole_array_clear_o <= 1'b1;
							vpp_enable_o <= 1'b1;
							wait_reg <= 32'(ERASE_CYC);
							state_reg <= ST_ERASE;
						end else begin
							op_code_pins_o <= `OPC_ADDR_IN; // [R02] [R19]
							sh_reg <= {q_cmd.addr, 12'h000};
							serial_addr_data_io_o <= q_cmd.addr[3];
							bits_reg <= 5'(`ADDR_BITS);
							state_reg <= ST_ADDR;
						end
					end
				end
				ST_ADDR, ST_DIN: begin
					if (fall) begin
						// msb first, next bit set up while clock is low [R03] [R06] [R21]
						sh_reg <= {sh_reg[14:0], 1'b0};
						serial_addr_data_io_o <= sh_reg[14];
						bits_reg <= bits_reg - 5'h01;
						if (bits_reg == 5'h01) begin
							if (state_reg == ST_DIN) begin
								// erase already done first, then program [R16] [R17]
								op_code_pins_o <= `OPC_WRITE;
								state_reg <= ST_PROG;
							end else if (cur_reg.kind == CMD_READ) begin
								op_code_pins_o <= `OPC_READ; // [R04]
								state_reg <= ST_READ;
							end else begin
								op_code_pins_o <= `OPC_WORD_ERASE; // [R07] [R19]
								state_reg <= ST_ERASE;
							end
						end
					end
				end
				ST_READ: begin
					if (fall) begin
						op_code_pins_o <= `OPC_DATA_OUT; // [R05]
						bits_reg <= 5'(`DATA_BITS);
						state_reg <= ST_DOUT;
					end
				end
				ST_DOUT: begin
					if (fall) begin
						// the device moves its pin on the rising edge, so take it late in the high phase
						sh_reg <= {sh_reg[14:0], serial_addr_data_io_i}; // [R05] [R21] [R15]
						bits_reg <= bits_reg - 5'h01;
						if (bits_reg == 5'h01) begin
							rsp_valid_o <= 1'b1;
							rsp_o <= '{addr: cur_reg.addr, data: {sh_reg[14:0], serial_addr_data_io_i}};
							op_code_pins_o <= `OPC_STANDBY_HI;
							state_reg <= ST_STBY;
						end
					end
				end
				ST_ERASE, ST_PROG: begin
					if (whole_array_clear_o) begin
						// clear has no strobe; its timer runs with the clock parked low [R14]
						if (wait_reg != '0) begin
							wait_reg <= wait_reg - 32'h1;
						end else begin
							whole_array_clear_o <= 1'b0;
							vpp_enable_o <= 1'b0;
							state_reg <= ST_IDLE;
							select_n_o <= 1'b1;
							busy_o <= 1'b0;
						end
					end else if (held_reg) begin
						// inputs held still while programming voltage is up [R18]
						if (wait_reg != '0) begin
							wait_reg <= wait_reg - 32'h1; // [R07] [R08]
						end else if (state_reg == ST_ERASE) begin
							held_reg <= 1'b0;
							erased_reg <= 1'b1;
							op_code_pins_o <= `OPC_DATA_IN; // [R06]
							sh_reg <= cur_reg.data;
							serial_addr_data_io_o <= cur_reg.data[15];
							bits_reg <= 5'(`DATA_BITS);
							vpp_enable_o <= 1'b0;
							state_reg <= ST_DIN;
						end else begin
							held_reg <= 1'b0;
							op_code_pins_o <= `OPC_STANDBY_HI; // [R08] [R10]
							vpp_enable_o <= 1'b0;
							state_reg <= ST_STBY;
						end
					end else if (rise) begin
						// supply comes up with the strobe, so no other code is clocked under it
						vpp_enable_o <= 1'b1; // [R07] [R08]
					end else if (fall) begin
						// erase or program time counts from the strobe, not before it [R07] [R08]
						held_reg <= 1'b1;
						wait_reg <= (state_reg == ST_ERASE) ? 32'(ERASE_CYC) : 32'(PROGRAM_CYC);
					end
				end
				ST_STBY: begin
					if (fall) begin
						erased_reg <= 1'b0;
						select_n_o <= 1'b1;
						busy_o <= 1'b0;
						state_reg <= ST_IDLE;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	// host drives the pin only while shifting address or data in [R11]
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			serial_addr_data_io_oe_o <= 1'b0;
		end else begin
			serial_addr_data_io_oe_o <= (state_reg == ST_ADDR) || (state_reg == ST_DIN);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// checks
	logic [5:0] edge_cnt;
	always_ff @(posedge clk_i) begin
		if (rst_i || state_reg != ST_DOUT) begin
			edge_cnt <= 6'h00;
		end else if (rise) begin
			edge_cnt <= edge_cnt + 6'h01;
		end
	end
	no_contention_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		(state_reg == ST_DOUT) |=> !serial_addr_data_io_oe_o)
		else $error("host drives pin during data out");
	vpp_write_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R08]
		(state_reg == ST_PROG && op_code_pins_o == `OPC_WRITE && wait_reg != '0) |-> vpp_enable_o)
		else $error("no programming voltage during write");
	erase_code_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
		(state_reg == ST_ERASE && !whole_array_clear_o) |-> op_code_pins_o == `OPC_WORD_ERASE)
		else $error("erase code not held");
	stable_pins_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R18]
		(state_reg inside {ST_ERASE, ST_PROG} && held_reg && $past(held_reg))
		|-> $stable(op_code_pins_o) && $stable(link_clk_o) && $stable(select_n_o))
		else $error("inputs move under programming voltage");
	held_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R07]
		(state_reg inside {ST_ERASE, ST_PROG} && held_reg) |-> !link_clk_o && vpp_enable_o)
		else $error("clock moved or supply off during timed step");
	sixteen_out_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R05]
		$rose(rsp_valid_o) |-> $past(edge_cnt) == 6'd16)
		else $error("read did not take sixteen pulses");
	write_after_erase_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R16]
		(op_code_pins_o == `OPC_WRITE) |-> erased_reg)
		else $error("write without erase");
	clear_vpp_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		whole_array_clear_o |-> vpp_enable_o && !link_clk_o)
		else $error("clear without programming voltage");
	deselect_idle_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		(state_reg == ST_IDLE && !q_valid && $past(state_reg) == ST_IDLE) |-> select_n_o)
		else $error("selected while idle");
	addr_msb_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R21]
		(state_reg == ST_ADDR && bits_reg == 5'h04) |-> serial_addr_data_io_o == cur_reg.addr[3])
		else $error("address not sent msb first");
	data_msb_a: assert property (@(posedge clk_i) disable iff (rst_i) // [R06]
		(state_reg == ST_DIN && bits_reg == 5'h10) |-> serial_addr_data_io_o == cur_reg.data[15])
		else $error("data not sent msb first");
	read_cov: cover property (@(posedge clk_i) rsp_valid_o);
	write_cov: cover property (@(posedge clk_i) state_reg == ST_PROG ##1 state_reg == ST_STBY);
	clear_cov: cover property (@(posedge clk_i) $fell(whole_array_clear_o));
	erase_cov: cover property (@(posedge clk_i) state_reg == ST_ERASE ##1 state_reg == ST_DIN);
endmodule // eeprom_host
`default_nettype wire

// *** eeprom_host_defines.svh ***
`ifndef EEPROM_HOST_DEFINES_SVH
`define EEPROM_HOST_DEFINES_SVH
// op codes as {third, second, first} control pin
`define OPC_WORD_ERASE 3'h4
`define OPC_WRITE 3'h2
`define OPC_DATA_OUT 3'h6
`define OPC_ADDR_IN 3'h1
`define OPC_DATA_IN 3'h5
`define OPC_READ 3'h3
`define OPC_STANDBY_HI 3'h7
`define OPC_STANDBY_LO 3'h0
// widths
`define ADDR_BITS 4
`define DATA_BITS 16
`define WORD_COUNT 16
// timing, clock at 20 MHz
`define CLK_HZ 20000000
`define ERASE_DURATION_MS 100
`define PROGRAM_DURATION_MS 10
`define ERASE_CYCLES ((`ERASE_DURATION_MS * `CLK_HZ) / 1000)
`define PROGRAM_CYCLES ((`PROGRAM_DURATION_MS * `CLK_HZ) / 1000)
// link clock phase: 5 us high, 5 us low minimum
`define LINK_PHASE_NS 5000
`define CLK_PERIOD_NS 50
`define PHASE_CYCLES ((`LINK_PHASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIFO_DEPTH 4
`endif

// *** eeprom_host_pkg.sv ***
package eeprom_host_pkg;
	typedef enum logic [1:0] {
		CMD_READ = 2'h0,
		CMD_WRITE = 2'h1,
		CMD_CLEAR = 2'h2
	} cmd_kind_t;
	typedef struct packed {
		cmd_kind_t kind;
		logic [3:0] addr;
		logic [15:0] data;
	} cmd_t;
	typedef struct packed {
		logic [3:0] addr;
		logic [15:0] data;
	} rsp_t;
endpackage

// *** word_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;
	logic [AW:0] cnt_next;
	assign out_valid_o = (cnt_reg != '0);
	assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
	assign out_data_o = mem_reg[rd_reg];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
			in_ready_o <= 1'b1;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_next;
			// registered room flag keeps the ready output straight off a flop
			in_ready_o <= (cnt_next != (AW+1)'(DEPTH));
		end
	end
endmodule // word_fifo
`default_nettype wire

// *** eeprom_device_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_host_defines.svh"
module eeprom_device_model #(
	parameter int ERASE_MIN = 48,
	parameter int PROG_MIN = 18
) (
	// host clock, used only to time the programming voltage
	input wire logic clk_i,
	// device pins
	input wire logic link_clk_i,
	input wire logic [2:0] op_code_pins_i,
	input wire logic select_n_i,
	input wire logic whole_array_clear_i,
	input wire logic vpp_i,
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o,
	output logic vctl_n_o
);
	logic [15:0] mem [16];
	logic [3:0] addr_reg = '0;
	logic [15:0] data_reg = '0;
	logic [2:0] op_reg = `OPC_STANDBY_HI;
	logic [2:0] op_seen = `OPC_STANDBY_HI;
	int vpp_cnt = 0;
	int clr_cnt = 0;
	// power-up contents are not erased, so a missing clear shows up in reads
	initial for (int i = 0; i < 16; i++) mem[i] = 16'h5a3c ^ 16'(i);
	////////////////////////////////////////////////////////////////////////////////
	// short programming voltage leaves the array untouched, as on silicon
	always @(posedge clk_i) begin
		op_seen <= op_reg;
		if (op_reg != op_seen) vpp_cnt <= 0;
		// only time with the clock parked after a strobe counts as erase or program time
		else if (vpp_i && !link_clk_i) vpp_cnt <= vpp_cnt + 1;
		clr_cnt <= (whole_array_clear_i && vpp_i) ? clr_cnt + 1 : 0;
		if (!whole_array_clear_i && clr_cnt >= ERASE_MIN) begin
			for (int i = 0; i < 16; i++) mem[i] = '0;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge link_clk_i) begin
		if (!select_n_i) begin
			if (op_reg == `OPC_WORD_ERASE && vpp_cnt >= ERASE_MIN) mem[addr_reg] = '0;
			if (op_reg == `OPC_WRITE && vpp_cnt >= PROG_MIN) mem[addr_reg] = mem[addr_reg] | data_reg;
			op_reg <= op_code_pins_i;
			case (op_code_pins_i)
				`OPC_ADDR_IN: addr_reg <= {addr_reg[2:0], pin_i};
				`OPC_DATA_IN: data_reg <= {data_reg[14:0], pin_i};
				`OPC_READ: data_reg <= mem[addr_reg];
				`OPC_DATA_OUT: begin
					pin_o <= data_reg[15];
					data_reg <= {data_reg[14:0], data_reg[15]};
				end
				default: ;
			endcase
		end
	end
	assign pin_oe_o = (op_reg == `OPC_DATA_OUT) && !select_n_i;
	assign vctl_n_o = !((op_reg inside {`OPC_WORD_ERASE, `OPC_WRITE}) && !select_n_i);
endmodule // eeprom_device_model
`default_nettype wire

// *** tb_eeprom_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(what, exp, got) begin checks_done++; if ((exp) !== (got)) begin errors++; \
	$display("unexpected %s: expected %h, seen %h", what, exp, got); end end
module tb_eeprom_host;
	import eeprom_host_pkg::*;
	localparam int ER = 50;
	localparam int PR = 20;
	logic clk_i = 0;
	logic rst_i = 1;
	logic cmd_valid_i = 0;
	cmd_t cmd_i = '0;
	logic cmd_ready_o, rsp_valid_o, busy_o, link_clk_o, select_n_o, whole_array_clear_o, vpp_enable_o;
	logic [2:0] op_code_pins_o;
	rsp_t rsp_o;
	rsp_t exp_rsp;
	logic vctl_n, host_o, host_oe, dev_o, dev_oe, pin;
	logic pin_last = 0;
	logic refused = 0;
	logic [15:0] shadow [16];
	logic [3:0] a_rand;
	rsp_t exp_q [$];
	int errors = 0;
	int checks_done = 0;
	int seed = 81;
	int cycles = 0;
	// an undriven pin shows the inverse of its last level, never a lucky match
	assign pin = host_oe ? host_o : dev_oe ? dev_o : ~pin_last;
	initial forever #25 clk_i = ~clk_i;
	eeprom_host #(.ERASE_CYC(ER), .PROGRAM_CYC(PR)) u_eeprom_host (.clk_i(clk_i), .rst_i(rst_i),
		.cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o), .cmd_i(cmd_i),
		.rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .busy_o(busy_o), .link_clk_o(link_clk_o),
		.op_code_pins_o(op_code_pins_o), .select_n_o(select_n_o),
		.whole_array_clear_o(whole_array_clear_o), .vpp_enable_o(vpp_enable_o),
		.prog_voltage_ctl_out_i(vctl_n), .serial_addr_data_io_i(pin),
		.serial_addr_data_io_o(host_o), .serial_addr_data_io_oe_o(host_oe));
	eeprom_device_model #(.ERASE_MIN(ER - 2), .PROG_MIN(PR - 2)) u_eeprom_device_model (
		.clk_i(clk_i), .link_clk_i(link_clk_o), .op_code_pins_i(op_code_pins_o),
		.select_n_i(select_n_o), .whole_array_clear_i(whole_array_clear_o),
		.vpp_i(vpp_enable_o), .pin_i(pin), .pin_o(dev_o), .pin_oe_o(dev_oe), .vctl_n_o(vctl_n));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// one idle edge between commands keeps valid from being set twice in a step
	task automatic send(input cmd_kind_t k, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		#1;
		cmd_valid_i = 1;
		cmd_i = '{k, a, d};
		while (cmd_ready_o !== 1'b1) begin
			refused = 1;
			@(posedge clk_i);
			#1;
		end
		@(posedge clk_i);
		#1;
		cmd_valid_i = 0;
		if (k == CMD_READ) exp_q.push_back(rsp_t'{a, shadow[a]});
		if (k == CMD_WRITE) shadow[a] = d;
		if (k == CMD_CLEAR) for (int i = 0; i < 16; i++) shadow[i] = '0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	always begin
		@(posedge clk_i);
		#1;
		cycles++;
		if (host_oe | dev_oe) pin_last = pin;
		`CHK("pin contention", 1'b0, host_oe & dev_oe)
		if (rsp_valid_o === 1'b1) begin
			if (exp_q.size() == 0) `CHK("spare answer", 1'b0, 1'b1)
			else begin
				exp_rsp = exp_q.pop_front();
				`CHK("read answer", exp_rsp, rsp_o)
			end
		end
		if (cycles > 90000) begin
			errors++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk_i);
		#1;
		rst_i = 0;
		`CHK("idle pins", 8'h08, {link_clk_o, op_code_pins_o, select_n_o, host_oe, busy_o, vpp_enable_o})
		send(CMD_CLEAR, 4'h0, 16'h0000);
		repeat (3) @(posedge clk_i);
		#1;
		`CHK("busy while clearing", 1'b1, busy_o)
		send(CMD_READ, 4'h0, 16'h0000);
		send(CMD_READ, 4'hf, 16'h0000);
		a_rand = 4'(($random(seed) & 7) + 4);
		send(CMD_READ, a_rand, 16'h0000);
		send(CMD_WRITE, 4'h0, 16'($random(seed)));
		send(CMD_WRITE, 4'hf, 16'($random(seed)));
		send(CMD_WRITE, a_rand, 16'($random(seed)));
		send(CMD_WRITE, 4'hf, 16'($random(seed)));
		`CHK("queue refusal", 1'b1, refused)
		send(CMD_READ, 4'h0, 16'h0000);
		send(CMD_READ, a_rand, 16'h0000);
		send(CMD_READ, 4'hf, 16'h0000);
		while (exp_q.size() != 0) @(posedge clk_i);
		for (int n = 0; n < 1000 && busy_o !== 1'b0; n++) @(posedge clk_i);
		#1;
		`CHK("idle after run", 1'b0, busy_o)
		`CHK("pin released", 2'b00, {host_oe, dev_oe})
		for (int i = 0; i < 16; i++) `CHK("stored word", shadow[i], u_eeprom_device_model.mem[i])
		end_of_test();
	end
endmodule // tb_eeprom_host
`default_nettype wire
